// >>> hw/rgbyc_defines.svh
// Register map, field positions and reset values of the colour converter
// Contract
// - Unoffset luma is green plus weighted red and blue differences; luma adds luma bias.
// - Chroma is scale times colour minus unoffset luma, plus chroma bias.
// - Conversion coefficients are held with 17 bits inside the multipliers.
// - Raw luma is rounded to intermediate width minus two bits.
// - Scaled luma and chroma are rounded to output width before the bias.
// - Intermediate width lies between input width plus four and 18.
// - Without saturation overflow wraps; with saturation it stops at the upper limit.
// - Lower clamping exists only when enabled and lifts underflow to the minimum.
// - Luma has its own programmable upper and lower limits; both chromas share one upper and one lower limit.
// - Default coefficients are 0.299, 0.114, 0.877283 and 0.492111.
// - Both stream sides run on the one shared stream clock.
`ifndef RGBYC_DEFINES_SVH
`define RGBYC_DEFINES_SVH

`define RGBYC_REG_CTRL 8'h00
`define RGBYC_REG_STATUS 8'h04
`define RGBYC_REG_PIXCNT 8'h08
`define RGBYC_REG_COEF0 8'h10
`define RGBYC_REG_BIAS0 8'h20
`define RGBYC_REG_LIM0 8'h30

`define RGBYC_CTRL_ENABLE 0
`define RGBYC_HSIZE_WORD 3'h2

`define RGBYC_COEF_BITS 17
`define RGBYC_COEF_FRAC 15
`define RGBYC_RED_WEIGHT_RST 17'h02646
`define RGBYC_BLUE_WEIGHT_RST 17'h00e98
`define RGBYC_RED_DIFF_RST 17'h0704b
`define RGBYC_BLUE_DIFF_RST 17'h03efe

`define RGBYC_LUMA_BIAS_DROP 4
`define RGBYC_CHROMA_BIAS_DROP 1
`define RGBYC_LIMIT_HI_MULT 240
`define RGBYC_LIMIT_LO_MULT 16
`define RGBYC_LIMIT_SCALE_BITS 8
`define RGBYC_MAX_MID_BITS 18
`define RGBYC_MID_MARGIN 4
`define RGBYC_RST_HOLD_CYCLES 32

`endif

// >>> hw/rgbyc_pkg.sv
// Types shared by the colour converter
package rgbyc_pkg;

  typedef enum logic [1:0] {
    RGBYC_IDLE = 2'b00,
    RGBYC_BUSY = 2'b01,
    RGBYC_NONSEQ = 2'b10,
    RGBYC_SEQ = 2'b11
  } rgbyc_htrans_e;

  typedef logic [31:0] rgbyc_word_t;

endpackage

// >>> hw/rgbyc_top.sv
// Pixel colour-space converter with AHB-Lite control and stream ports
`timescale 1ns/1ns
`include "rgbyc_defines.svh"

module rgbyc_top #(
  parameter int IW = 8,
  parameter int OW = 8,
  parameter int MW = 12,
  parameter bit HAS_CLIPPING = 1'b1,
  parameter bit HAS_CLAMPING = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire rgbyc_pkg::rgbyc_htrans_e HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire rgbyc_pkg::rgbyc_word_t HWDATA,
  input wire logic HREADY,
  output rgbyc_pkg::rgbyc_word_t HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [3*IW-1:0] S_TDATA,
  input wire logic S_TVALID,
  input wire logic S_TUSER,
  input wire logic S_TLAST,
  output logic S_TREADY,
  output logic [3*OW-1:0] M_TDATA,
  output logic M_TVALID,
  output logic M_TUSER,
  output logic M_TLAST,
  input wire logic M_TREADY
);
  import rgbyc_pkg::*;

  localparam int EW = 3 * IW + 2;
  localparam int FR = `RGBYC_COEF_FRAC;
  localparam int YF = MW - 2 - IW;
  localparam int CW = `RGBYC_COEF_BITS;

  if (MW < IW + `RGBYC_MID_MARGIN || MW > `RGBYC_MAX_MID_BITS || OW > MW - 3 ||
      OW < `RGBYC_LIMIT_SCALE_BITS || OW < IW || YF >= FR) begin : g_bad_width
    $error("rgbyc_top: unsupported width parameters");
  end

  typedef struct packed {
    logic [1:0][EW-1:0] fifo;
    logic wptr;
    logic rptr;
    logic [1:0] cnt;
    logic s_ready;
    logic m_valid;
    logic [3*OW-1:0] m_data;
    logic m_user;
    logic m_last;
    logic ph_wr;
    logic ph_rd;
    logic [7:0] ph_addr;
    logic ready_out;
    logic resp;
    logic [31:0] rdata;
    logic enable;
    logic [3:0][CW-1:0] coef;
    logic [2:0][OW-1:0] bias;
    logic [3:0][OW-1:0] lim;
    logic [31:0] pix_cnt;
  } rgbyc_state_s;

  localparam logic [OW-1:0] LUMA_BIAS_RST = OW'(1 << (OW - `RGBYC_LUMA_BIAS_DROP));
  localparam logic [OW-1:0] CHROMA_BIAS_RST = OW'(1 << (OW - `RGBYC_CHROMA_BIAS_DROP));
  localparam logic [OW-1:0] LIM_HI_RST = OW'(`RGBYC_LIMIT_HI_MULT << (OW - `RGBYC_LIMIT_SCALE_BITS));
  localparam logic [OW-1:0] LIM_LO_RST = OW'(`RGBYC_LIMIT_LO_MULT << (OW - `RGBYC_LIMIT_SCALE_BITS));

  localparam rgbyc_state_s ST_RST = '{
    enable: 1'b1,
    ready_out: 1'b1,
    coef: {`RGBYC_BLUE_DIFF_RST, `RGBYC_RED_DIFF_RST, `RGBYC_BLUE_WEIGHT_RST, `RGBYC_RED_WEIGHT_RST},
    bias: {CHROMA_BIAS_RST, CHROMA_BIAS_RST, LUMA_BIAS_RST},
    lim: {LIM_LO_RST, LIM_HI_RST, LIM_LO_RST, LIM_HI_RST},
    default: '0
  };

  logic rst_meta;
  logic rst_n;
  rgbyc_state_s st;
  rgbyc_state_s nx;
  logic [EW-1:0] head;
  logic push;
  logic pop;
  logic sel;
  logic [31:0] rd;
  logic signed [47:0] rs;
  logic signed [47:0] gs;
  logic signed [47:0] bs;
  logic signed [47:0] kr;
  logic signed [47:0] kb;
  logic signed [47:0] kc;
  logic signed [47:0] kd;
  logic signed [47:0] acc;
  logic signed [47:0] y_raw;
  logic signed [47:0] yv;
  logic signed [47:0] crv;
  logic signed [47:0] cbv;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic logic signed [47:0] rnd(input logic signed [47:0] v, input int sh);
    rnd = (v + (48'sd1 <<< (sh - 1))) >>> sh;
  endfunction

  // Limits act on the biased value; a plain truncation wraps
  function automatic logic [OW-1:0] bound(input logic signed [47:0] v, input logic [OW-1:0] hi,
                                          input logic [OW-1:0] lo);
    logic signed [47:0] h;
    logic signed [47:0] l;
    h = signed'(48'(hi));
    l = signed'(48'(lo));
    bound = v[OW-1:0];
    if (HAS_CLIPPING && v > h) begin
      bound = hi;
    end else if (HAS_CLAMPING && v < l) begin
      bound = lo;
    end
  endfunction

  always_comb begin
    nx = st;
    rd = 32'h0000_0000;
    head = st.fifo[st.rptr];
    rs = 48'(head[IW-1:0]);
    gs = 48'(head[2*IW-1:IW]);
    bs = 48'(head[3*IW-1:2*IW]);
    kr = 48'(signed'(st.coef[0]));
    kb = 48'(signed'(st.coef[1]));
    kc = 48'(signed'(st.coef[2]));
    kd = 48'(signed'(st.coef[3]));
    acc = kr * (rs - gs) + kb * (bs - gs);
    y_raw = rnd(acc, FR - YF) + (gs <<< YF);
    yv = rnd(y_raw, YF + IW - OW) + signed'(48'(st.bias[0]));
    crv = rnd(kc * ((rs <<< YF) - y_raw), YF + FR + IW - OW) + signed'(48'(st.bias[1]));
    cbv = rnd(kd * ((bs <<< YF) - y_raw), YF + FR + IW - OW) + signed'(48'(st.bias[2]));
    push = S_TVALID && st.s_ready;
    pop = (st.cnt != 2'd0) && (!st.m_valid || M_TREADY);
    sel = HSEL && HREADY && (HTRANS == RGBYC_NONSEQ || HTRANS == RGBYC_SEQ);

    case (st.ph_addr)
      `RGBYC_REG_CTRL: rd[`RGBYC_CTRL_ENABLE] = st.enable;
      `RGBYC_REG_STATUS: rd = {29'h0, st.cnt, st.m_valid};
      `RGBYC_REG_PIXCNT: rd = st.pix_cnt;
      default: rd = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (st.ph_addr == 8'(`RGBYC_REG_COEF0 + 4 * i)) begin
        rd = 32'(st.coef[i]);
      end
      if (st.ph_addr == 8'(`RGBYC_REG_LIM0 + 4 * i)) begin
        rd = 32'(st.lim[i]);
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (st.ph_addr == 8'(`RGBYC_REG_BIAS0 + 4 * i)) begin
        rd = 32'(st.bias[i]);
      end
    end

    // Write data phase: registers update at its closing edge
    if (st.ph_wr) begin
      if (st.ph_addr == `RGBYC_REG_CTRL) begin
        nx.enable = HWDATA[`RGBYC_CTRL_ENABLE];
      end
      if (st.ph_addr == `RGBYC_REG_PIXCNT) begin
        nx.pix_cnt = 32'h0000_0000;
      end
      for (int i = 0; i < 4; i++) begin
        if (st.ph_addr == 8'(`RGBYC_REG_COEF0 + 4 * i)) begin
          nx.coef[i] = HWDATA[CW-1:0];
        end
        if (st.ph_addr == 8'(`RGBYC_REG_LIM0 + 4 * i)) begin
          nx.lim[i] = HWDATA[OW-1:0];
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (st.ph_addr == 8'(`RGBYC_REG_BIAS0 + 4 * i)) begin
          nx.bias[i] = HWDATA[OW-1:0];
        end
      end
    end

    // Reads get one wait state so a preceding write is already visible
    nx.ph_wr = 1'b0;
    if (st.ph_rd) begin
      nx.rdata = rd;
      nx.ready_out = 1'b1;
      nx.ph_rd = 1'b0;
    end else if (sel) begin
      nx.ph_addr = HADDR[7:0];
      nx.ph_wr = HWRITE && (HSIZE == `RGBYC_HSIZE_WORD);
      nx.ph_rd = !HWRITE;
      nx.ready_out = HWRITE;
    end

    // Output stage holds while downstream stalls
    if (st.m_valid && M_TREADY) begin
      nx.m_valid = 1'b0;
      nx.pix_cnt = nx.pix_cnt + 32'h0000_0001;
    end
    if (pop) begin
      nx.m_valid = 1'b1;
      nx.m_data = {bound(cbv, st.lim[2], st.lim[3]), bound(crv, st.lim[2], st.lim[3]),
                   bound(yv, st.lim[0], st.lim[1])};
      nx.m_user = head[EW-2];
      nx.m_last = head[EW-1];
      nx.rptr = ~st.rptr;
    end

    // Two-entry buffer; its registered ready stalls upstream
    if (push) begin
      nx.fifo[st.wptr] = {S_TLAST, S_TUSER, S_TDATA};
      nx.wptr = ~st.wptr;
    end
    nx.cnt = st.cnt + 2'(push) - 2'(pop);
    nx.s_ready = (nx.cnt != 2'd2) && nx.enable;
  end

  // Stream and bus share CLOCK
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign HRDATA = st.rdata;
  assign HREADYOUT = st.ready_out;
  assign HRESP = st.resp;
  assign S_TREADY = st.s_ready;
  assign M_TDATA = st.m_data;
  assign M_TVALID = st.m_valid;
  assign M_TUSER = st.m_user;
  assign M_TLAST = st.m_last;

  logic gray;
  logic bias_in;
  assign gray = (head[IW-1:0] == head[2*IW-1:IW]) && (head[IW-1:0] == head[3*IW-1:2*IW]);
  assign bias_in = (st.bias[1] <= st.lim[2]) && (st.bias[1] >= st.lim[3]);

  a_ready_full: assert property (
    @(posedge CLOCK) disable iff (!rst_n) st.cnt == 2'd2 |-> !S_TREADY)
    else $error("input ready high with a full buffer");

  a_hold_stall: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    M_TVALID && !M_TREADY |=> M_TVALID && $stable(M_TDATA) && $stable(M_TLAST))
    else $error("output changed while stalled");

  a_marker_pass: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    pop |=> M_TVALID && M_TUSER == $past(head[EW-2]) && M_TLAST == $past(head[EW-1]))
    else $error("frame markers lost in the pipeline");

  a_clip_luma: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    pop && HAS_CLIPPING && st.lim[1] <= st.lim[0] |=> M_TDATA[OW-1:0] <= $past(st.lim[0]))
    else $error("luma above its upper limit");

  a_clamp_luma: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    pop && HAS_CLAMPING && st.lim[1] <= st.lim[0] |=> M_TDATA[OW-1:0] >= $past(st.lim[1]))
    else $error("luma below its lower limit");

  a_clip_chroma: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    pop && HAS_CLIPPING && HAS_CLAMPING && st.lim[3] <= st.lim[2] |=>
    M_TDATA[3*OW-1:2*OW] <= $past(st.lim[2]) && M_TDATA[3*OW-1:2*OW] >= $past(st.lim[3]))
    else $error("chroma outside its limits");

  a_gray_chroma: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    pop && gray && bias_in |=> M_TDATA[2*OW-1:OW] == $past(st.bias[1]))
    else $error("grey pixel did not give the chroma bias");

  a_rd_wait: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    sel && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read did not finish after one wait state");

  // Bus, counter and stream timing checks, and the red chroma limit check
  a_wr_nowait: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    sel && HWRITE |=> HREADYOUT)
    else $error("write data phase was stretched");

  a_rdata_hold: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    !st.ph_rd |=> $stable(HRDATA))
    else $error("read data changed without a read");

  a_narrow_write: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    sel && HWRITE && HSIZE != `RGBYC_HSIZE_WORD |=>
    ##1 $stable(st.enable) && $stable(st.coef) && $stable(st.bias) && $stable(st.lim))
    else $error("narrow write changed a register");

  a_count_beat: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    M_TVALID && M_TREADY && !(st.ph_wr && st.ph_addr == `RGBYC_REG_PIXCNT) |=>
    st.pix_cnt == $past(st.pix_cnt) + 32'h0000_0001)
    else $error("output handshake not counted");

  a_count_clear: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    st.ph_wr && st.ph_addr == `RGBYC_REG_PIXCNT |=> st.pix_cnt == 32'($past(M_TVALID && M_TREADY)))
    else $error("pixel count clear lost against a handshake");

  a_enable_gate: assert property (
    @(posedge CLOCK) disable iff (!rst_n) !st.enable |-> !S_TREADY)
    else $error("input ready while disabled");

  a_first_beat: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    push && st.cnt == 2'd0 && !st.m_valid |=> ##1 M_TVALID)
    else $error("pixel not shown two edges after it was taken");

  a_clip_red: assert property (
    @(posedge CLOCK) disable iff (!rst_n)
    pop && HAS_CLIPPING && HAS_CLAMPING && st.lim[3] <= st.lim[2] |=>
    M_TDATA[2*OW-1:OW] <= $past(st.lim[2]) && M_TDATA[2*OW-1:OW] >= $past(st.lim[3]))
    else $error("red chroma outside its limits");

  c_stall: cover property (@(posedge CLOCK) disable iff (!rst_n) M_TVALID && !M_TREADY ##1 M_TREADY);
  c_full: cover property (@(posedge CLOCK) disable iff (!rst_n) st.cnt == 2'd2);
  c_clip: cover property (@(posedge CLOCK) disable iff (!rst_n) pop && yv > signed'(48'(st.lim[0])));
  c_frame: cover property (@(posedge CLOCK) disable iff (!rst_n) M_TVALID && M_TREADY && M_TUSER);
  c_narrow: cover property (@(posedge CLOCK) disable iff (!rst_n) sel && HWRITE && HSIZE != `RGBYC_HSIZE_WORD);

endmodule

// >>> tb/rgbyc_stream_partner.sv
// Upstream source and downstream sink around the converter
`timescale 1ns/1ns
module rgbyc_stream_partner (
  input wire logic clock,
  input wire logic stall,
  output logic [23:0] s_tdata,
  output logic s_tvalid,
  output logic s_tuser,
  output logic s_tlast,
  input wire logic s_tready,
  input wire logic [23:0] m_tdata,
  input wire logic m_tvalid,
  input wire logic m_tuser,
  input wire logic m_tlast,
  output logic m_tready
);
  logic [25:0] src_q[$];
  logic [25:0] snk_q[$];
  initial begin
    {s_tuser, s_tlast, s_tdata} = 26'h0;
    s_tvalid = 1'b0;
    m_tready = 1'b0;
  end
  // A beat holds until ready is seen; idle data toggles so stale values never match
  always @(posedge clock) begin
    m_tready <= !stall;
    if (m_tvalid && m_tready) snk_q.push_back({m_tuser, m_tlast, m_tdata});
    if (!s_tvalid || s_tready) begin
      s_tvalid <= src_q.size() > 0;
      {s_tuser, s_tlast, s_tdata} <= src_q.size() > 0 ? src_q.pop_front() : ~{s_tuser, s_tlast, s_tdata};
    end
  end
endmodule

// >>> tb/rgb_to_ycrcb_matrix_tb.sv
// Self-checking bench of the colour converter
`timescale 1ns/1ns
`include "rgbyc_defines.svh"
module rgb_to_ycrcb_matrix_tb;
  import rgbyc_pkg::*;
  localparam int YF = 12 - 2 - 8;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  rgbyc_htrans_e htrans = RGBYC_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  rgbyc_word_t hwdata = 32'h0;
  rgbyc_word_t hrdata;
  rgbyc_word_t rd;
  logic hreadyout;
  logic hresp;
  logic stall = 1'b0;
  logic [23:0] s_tdata;
  logic [23:0] m_tdata;
  logic s_tvalid, s_tuser, s_tlast, s_tready, m_tvalid, m_tuser, m_tlast, m_tready;
  int fail_count = 0;
  int checks = 0;
  int kr = `RGBYC_RED_WEIGHT_RST;
  int kb = `RGBYC_BLUE_WEIGHT_RST;
  int kc = `RGBYC_RED_DIFF_RST;
  int kd = `RGBYC_BLUE_DIFF_RST;
  int yhi = 240;
  int clo = 16;
  logic [25:0] exp_q[$];
  logic [39:0] regs[15] = '{40'h0000000001, 40'h0400000000, 40'h0800000000, 40'h1000002646,
    40'h1400000e98, 40'h180000704b, 40'h1c00003efe, 40'h2000000010, 40'h2400000080, 40'h2800000080,
    40'h30000000f0, 40'h3400000010, 40'h38000000f0, 40'h3c00000010, 40'h4000000000};
  logic [25:0] pix[8] = '{26'h0ffffff, 26'h2000000, 26'h00000ff, 26'h000ff00, 26'h0ff0000,
    26'h0102030, 26'h0f0801f, 26'h1405060};

  always #20 clock = ~clock;

  rgbyc_top u_rgbyc_top (
    .CLOCK(clock), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .S_TDATA(s_tdata), .S_TVALID(s_tvalid), .S_TUSER(s_tuser), .S_TLAST(s_tlast),
    .S_TREADY(s_tready), .M_TDATA(m_tdata), .M_TVALID(m_tvalid), .M_TUSER(m_tuser),
    .M_TLAST(m_tlast), .M_TREADY(m_tready)
  );

  rgbyc_stream_partner u_rgbyc_stream_partner (
    .clock(clock), .stall(stall), .s_tdata(s_tdata), .s_tvalid(s_tvalid), .s_tuser(s_tuser),
    .s_tlast(s_tlast), .s_tready(s_tready), .m_tdata(m_tdata), .m_tvalid(m_tvalid),
    .m_tuser(m_tuser), .m_tlast(m_tlast), .m_tready(m_tready)
  );

  function automatic logic [7:0] lim(input int v, input int hi, input int lo);
    if (v > hi) return 8'(hi);
    if (v < lo) return 8'(lo);
    return 8'(v);
  endfunction

  function automatic logic [23:0] conv(input int r, input int g, input int b);
    int yp, cr, cbd;
    yp = (g <<< YF) + ((kr * (r - g) + kb * (b - g) + (1 <<< 12)) >>> 13);
    cr = ((kc * ((r <<< YF) - yp) + (1 <<< 16)) >>> 17) + 128;
    cbd = ((kd * ((b <<< YF) - yp) + (1 <<< 16)) >>> 17) + 128;
    return {lim(cbd, 240, clo), lim(cr, 240, clo), lim(((yp + 2) >>> YF) + 16, yhi, 16)};
  endfunction

  task automatic check(input rgbyc_word_t got, input rgbyc_word_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One AHB single transfer; read data taken at the falling edge before the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input rgbyc_word_t wd, input logic [2:0] sz,
                     output rgbyc_word_t rdv);
    logic rdy;
    int w;
    hsel <= 1'b1;
    htrans <= RGBYC_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    w = 0;
    do begin
      @(negedge clock);
      rdy = hreadyout;
      @(posedge clock);
      w++;
    end while (!rdy && w < 50);
    hsel <= 1'b0;
    htrans <= RGBYC_IDLE;
    hwdata <= wd;
    do begin
      @(negedge clock);
      rdy = hreadyout;
      rdv = hrdata;
      check(32'(hresp), 32'h0);
      @(posedge clock);
      w++;
    end while (!rdy && w < 50);
    check(32'(rdy), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input rgbyc_word_t d);
    bus(1'b1, a, d, `RGBYC_HSIZE_WORD, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input rgbyc_word_t e);
    bus(1'b0, a, 32'h0, `RGBYC_HSIZE_WORD, rd);
    check(rd, e);
  endtask

  task automatic send(input logic [25:0] p);
    u_rgbyc_stream_partner.src_q.push_back(p);
    exp_q.push_back({p[25:24], conv(p[7:0], p[15:8], p[23:16])});
  endtask

  task automatic drain();
    int w;
    w = 0;
    while (exp_q.size() > 0 && w < 500) begin
      @(posedge clock);
      w++;
      while (u_rgbyc_stream_partner.snk_q.size() > 0 && exp_q.size() > 0)
        check(32'(u_rgbyc_stream_partner.snk_q.pop_front()), 32'(exp_q.pop_front()));
    end
    check(32'(w < 500), 32'h1);
  endtask

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (regs[i]) rdc(regs[i][39:32], regs[i][31:0]);
    foreach (pix[i]) send(pix[i]);
    drain();
    // Stalled sink: buffer fills, input is refused, nothing is lost
    stall <= 1'b1;
    for (int i = 0; i < 5; i++) send(26'h0804020 + 26'(i));
    repeat (20) @(posedge clock);
    rdc(8'h04, 32'h5);
    @(negedge clock);
    check(32'(s_tready), 32'h0);
    check(32'(u_rgbyc_stream_partner.snk_q.size()), 32'h0);
    @(posedge clock);
    stall <= 1'b0;
    drain();
    rdc(8'h08, 32'd13);
    wr(8'h08, 32'h0);
    rdc(8'h08, 32'h0);
    wr(8'h44, 32'hffffffff);
    rdc(8'h44, 32'h0);
    // Byte-sized write must leave the luma lower limit alone
    bus(1'b1, 8'h34, 32'h63, 3'h0, rd);
    rdc(8'h34, 32'h10);
    wr(8'h30, 32'd100);
    yhi = 100;
    wr(8'h3c, 32'd144);
    clo = 144;
    send(26'h0ffffff);
    send(26'h0000000);
    send(26'h00000ff);
    drain();
    wr(8'h10, 32'hffffe000);
    rdc(8'h10, 32'h0001e000);
    kr = -8192;
    wr(8'h14, 32'h0);
    kb = 0;
    send(26'h00a32c8);
    drain();
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(32'(s_tready), 32'h0);
    send(26'h0102030);
    repeat (10) @(posedge clock);
    check(32'(u_rgbyc_stream_partner.snk_q.size()), 32'h0);
    wr(8'h00, 32'h1);
    drain();
    // Reset in mid-run with pixels held inside
    stall <= 1'b1;
    send(26'h0112233);
    send(26'h0445566);
    repeat (6) @(posedge clock);
    rst_b <= 1'b0;
    repeat (`RGBYC_RST_HOLD_CYCLES) @(posedge clock);
    check(32'({m_tvalid, s_tready}), 32'h0);
    exp_q.delete();
    rst_b <= 1'b1;
    stall <= 1'b0;
    kr = `RGBYC_RED_WEIGHT_RST;
    kb = `RGBYC_BLUE_WEIGHT_RST;
    yhi = 240;
    clo = 16;
    repeat (3) @(posedge clock);
    rdc(8'h30, 32'd240);
    send(26'h0ffffff);
    drain();
    end_of_test();
  end
endmodule
